// ===== core/ssa_cfg.svh
`ifndef SSA_CFG_SVH
`define SSA_CFG_SVH
// register byte offsets
`define SSA_OFF_DATA_LINE 12'h000
`define SSA_OFF_CLOCK_LINE 12'h004
`define SSA_OFF_CTRL 12'h008
`define SSA_OFF_COND1 12'h00C
`define SSA_OFF_COND2 12'h010
`define SSA_OFF_SAMPLED 12'h014
`define SSA_OFF_NEW_SAMPLE 12'h018
// control field positions
`define SSA_CTRL_ENABLE 0
`define SSA_CTRL_STRETCH_EN 1
`define SSA_CTRL_COND_STRETCH_EN 2
`define SSA_CTRL_STRETCH_ACTIVE 3
// reset values
`define SSA_RST_LINE_OUT 1'b1
`define SSA_RST_CTRL_BIT 1'b0
`define SSA_RST_FLAG 1'b0
// port b bit positions taken over
`define SSA_PB_CLOCK_BIT 4
`define SSA_PB_DATA_BIT 5
`endif

// ===== core/ssa_pkg.sv
package ssa_pkg;
    // apb request bundle
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } ssa_apb_req_s;
    // synchronised line levels
    typedef struct packed {
        logic clock_line;
        logic data_line;
    } ssa_lines_s;
    // stretch state machine
    typedef enum logic [1:0] {
        SSA_ST_IDLE = 2'b01,
        SSA_ST_HOLD = 2'b10
    } ssa_stretch_e;
endpackage

// ===== core/ssa_sync_serial_assist.sv
// The register offsets and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ns
`include "ssa_cfg.svh"
module ssa_sync_serial_assist (
    input wire logic clk_i, // system clock 50 MHz
    input wire logic rst_i, // synchronous reset, high
    input wire logic ce_i, // clock enable, freezes state when low
    input wire ssa_pkg::ssa_apb_req_s apb_i, // apb request
    output logic [31:0] prdata_o, // apb read data
    output logic pready_o, // apb ready
    output logic pslverr_o, // apb error for unmapped
    input wire logic [7:0] port_b_out_i, // normal port drive values
    input wire logic [7:0] port_b_oe_i, // normal port drive enables
    input wire logic [7:0] port_b_line_i, // pad levels
    output logic [7:0] port_b_line_o, // pad drive values
    output logic [7:0] port_b_line_oe_o, // pad drive enables
    output logic first_condition_irq_o, // condition 1 pulse
    output logic second_condition_irq_o // condition 2 pulse
);
    // ==========================================================
    // registers and synchronisers
    logic data_line_out_r;
    logic clock_line_out_r;
    logic block_enable_r;
    logic stretch_enable_r;
    logic conditional_stretch_enable_r;
    logic first_condition_flag_r;
    logic second_condition_flag_r;
    logic sampled_data_bit_r;
    logic new_sample_flag_r;
    logic rise_at_setup_r;
    ssa_pkg::ssa_stretch_e stretch_r;
    ssa_pkg::ssa_lines_s meta_r;
    ssa_pkg::ssa_lines_s sync_r;
    ssa_pkg::ssa_lines_s prev_r;
    logic stretch_active_flag;
    logic wr_en;
    logic rd_en;
    logic mapped;
    logic clk_rise;
    logic clk_fall;
    logic data_rise;
    logic data_fall;
    logic cond1_hit;
    logic cond2_hit;
    logic [31:0] rdata_nxt;

    // ==========================================================
    // apb decode: zero wait states, access phase is the write moment
    assign pready_o = 1'b1;
    assign wr_en = ce_i && apb_i.psel && apb_i.penable && apb_i.pwrite;
    assign rd_en = ce_i && apb_i.psel && apb_i.penable && !apb_i.pwrite;
    assign stretch_active_flag = (stretch_r == ssa_pkg::SSA_ST_HOLD);

    // address decode and read mux, pins rather than stored values
    always_comb
    begin
        mapped = 1'b1;
        rdata_nxt = 32'h0000_0000;
        if (apb_i.paddr == `SSA_OFF_DATA_LINE)
        begin
            rdata_nxt[0] = sync_r.data_line;
        end
        else if (apb_i.paddr == `SSA_OFF_CLOCK_LINE)
        begin
            rdata_nxt[0] = sync_r.clock_line;
        end
        else if (apb_i.paddr == `SSA_OFF_CTRL)
        begin
            rdata_nxt[`SSA_CTRL_ENABLE] = block_enable_r;
            rdata_nxt[`SSA_CTRL_STRETCH_EN] = stretch_enable_r;
            rdata_nxt[`SSA_CTRL_COND_STRETCH_EN] = conditional_stretch_enable_r;
            rdata_nxt[`SSA_CTRL_STRETCH_ACTIVE] = stretch_active_flag;
        end
        else if (apb_i.paddr == `SSA_OFF_COND1)
        begin
            rdata_nxt[0] = first_condition_flag_r;
        end
        else if (apb_i.paddr == `SSA_OFF_COND2)
        begin
            rdata_nxt[0] = second_condition_flag_r;
        end
        else if (apb_i.paddr == `SSA_OFF_SAMPLED)
        begin
            rdata_nxt[0] = sampled_data_bit_r;
        end
        else if (apb_i.paddr == `SSA_OFF_NEW_SAMPLE)
        begin
            rdata_nxt[0] = new_sample_flag_r;
        end
        else
        begin
            mapped = 1'b0;
        end
    end

    // read data from a flop: captured in setup, stands through access
    // keeps zero wait states at the cost of one cycle of pin staleness
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            prdata_o <= 32'h0000_0000;
        end
        else if (ce_i)
        begin
            prdata_o <= (apb_i.psel && !apb_i.penable) ? rdata_nxt : 32'h0000_0000;
        end
    end

    // error stays combinational, it qualifies the handshake
    assign pslverr_o = apb_i.psel && apb_i.penable && !mapped;

    // ==========================================================
    // writable registers
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            data_line_out_r <= `SSA_RST_LINE_OUT;
            clock_line_out_r <= `SSA_RST_LINE_OUT;
            block_enable_r <= `SSA_RST_CTRL_BIT;
            stretch_enable_r <= `SSA_RST_CTRL_BIT;
            conditional_stretch_enable_r <= `SSA_RST_CTRL_BIT;
        end
        else if (wr_en)
        begin
            if (apb_i.paddr == `SSA_OFF_DATA_LINE)
            begin
                data_line_out_r <= apb_i.pwdata[0];
            end
            else if (apb_i.paddr == `SSA_OFF_CLOCK_LINE)
            begin
                clock_line_out_r <= apb_i.pwdata[0];
            end
            else if (apb_i.paddr == `SSA_OFF_CTRL)
            begin
                block_enable_r <= apb_i.pwdata[`SSA_CTRL_ENABLE];
                stretch_enable_r <= apb_i.pwdata[`SSA_CTRL_STRETCH_EN];
                conditional_stretch_enable_r <= apb_i.pwdata[`SSA_CTRL_COND_STRETCH_EN];
            end
        end
    end

    // ==========================================================
    // line synchronisers, first stage read only by second
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            meta_r <= '1;
            sync_r <= '1;
            prev_r <= '1;
        end
        else if (ce_i)
        begin
            meta_r.clock_line <= port_b_line_i[`SSA_PB_CLOCK_BIT];
            meta_r.data_line <= port_b_line_i[`SSA_PB_DATA_BIT];
            sync_r <= meta_r;
            prev_r <= sync_r;
        end
    end

    // edges from synchronised values only; direction plays no part
    assign clk_rise = sync_r.clock_line && !prev_r.clock_line;
    assign clk_fall = !sync_r.clock_line && prev_r.clock_line;
    assign data_rise = sync_r.data_line && !prev_r.data_line;
    assign data_fall = !sync_r.data_line && prev_r.data_line;
    // clock must be high before and after the data edge
    assign cond1_hit = ce_i && block_enable_r && data_fall
        && sync_r.clock_line && prev_r.clock_line;
    assign cond2_hit = ce_i && block_enable_r && data_rise
        && sync_r.clock_line && prev_r.clock_line;

    // ==========================================================
    // condition flags: detection wins over a clearing write
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            first_condition_flag_r <= `SSA_RST_FLAG;
            second_condition_flag_r <= `SSA_RST_FLAG;
        end
        else
        begin
            if (cond1_hit)
            begin
                first_condition_flag_r <= 1'b1;
            end
            else if (wr_en && apb_i.paddr == `SSA_OFF_COND1)
            begin
                first_condition_flag_r <= 1'b0;
            end
            if (cond2_hit)
            begin
                second_condition_flag_r <= 1'b1;
            end
            else if (wr_en && apb_i.paddr == `SSA_OFF_COND2)
            begin
                second_condition_flag_r <= 1'b0;
            end
        end
    end

    // one-cycle interrupt pulses, registered
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            first_condition_irq_o <= 1'b0;
            second_condition_irq_o <= 1'b0;
        end
        else if (ce_i)
        begin
            first_condition_irq_o <= cond1_hit;
            second_condition_irq_o <= cond2_hit;
        end
    end

    // ==========================================================
    // sampling on clock rise; a read clears, a new rise wins
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            sampled_data_bit_r <= `SSA_RST_FLAG;
            new_sample_flag_r <= `SSA_RST_FLAG;
            rise_at_setup_r <= 1'b0;
        end
        else if (ce_i)
        begin
            // a sample landing on the setup edge was not in the read data
            rise_at_setup_r <= clk_rise;
            if (clk_rise)
            begin
                sampled_data_bit_r <= sync_r.data_line;
                new_sample_flag_r <= 1'b1;
            end
            else if (rd_en && apb_i.paddr == `SSA_OFF_SAMPLED && !rise_at_setup_r)
            begin
                new_sample_flag_r <= 1'b0;
            end
        end
    end

    // ==========================================================
    // stretch machine; a same-cycle release write does not stop a fall entering hold
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            stretch_r <= ssa_pkg::SSA_ST_IDLE;
        end
        else if (ce_i)
        begin
            case (stretch_r)
                ssa_pkg::SSA_ST_IDLE:
                begin
                    if (block_enable_r && clk_fall && (stretch_enable_r
                        || (conditional_stretch_enable_r && first_condition_flag_r)))
                    begin
                        stretch_r <= ssa_pkg::SSA_ST_HOLD;
                    end
                end
                ssa_pkg::SSA_ST_HOLD:
                begin
                    if (wr_en && apb_i.paddr == `SSA_OFF_SAMPLED)
                    begin
                        stretch_r <= ssa_pkg::SSA_ST_IDLE;
                    end
                end
                default:
                begin
                    stretch_r <= ssa_pkg::SSA_ST_IDLE;
                end
            endcase
        end
    end

    // ==========================================================
    // pad muxing: open drain, drive low only, ignore port direction
    always_comb
    begin
        port_b_line_o = port_b_out_i;
        port_b_line_oe_o = port_b_oe_i;
        if (block_enable_r)
        begin
            port_b_line_o[`SSA_PB_CLOCK_BIT] = 1'b0;
            port_b_line_o[`SSA_PB_DATA_BIT] = 1'b0;
            port_b_line_oe_o[`SSA_PB_CLOCK_BIT] = !clock_line_out_r
                || stretch_active_flag;
            port_b_line_oe_o[`SSA_PB_DATA_BIT] = !data_line_out_r;
        end
    end

    // ==========================================================
    // checks
    property p_cond1_sets;
        @(posedge clk_i) disable iff (rst_i) cond1_hit |=> first_condition_flag_r;
    endproperty
    a_cond1_sets: assert property (p_cond1_sets) else $error("flag1 not set");

    property p_cond1_clear;
        @(posedge clk_i) disable iff (rst_i)
        (wr_en && apb_i.paddr == `SSA_OFF_COND1 && !cond1_hit) |=> !first_condition_flag_r;
    endproperty
    a_cond1_clear: assert property (p_cond1_clear) else $error("flag1 not cleared");

    property p_irq1;
        @(posedge clk_i) disable iff (rst_i)
        $rose(first_condition_flag_r) |-> first_condition_irq_o;
    endproperty
    a_irq1: assert property (p_irq1) else $error("irq1 missing");

    property p_cond2_sets;
        @(posedge clk_i) disable iff (rst_i)
        cond2_hit |=> second_condition_flag_r && second_condition_irq_o;
    endproperty
    a_cond2_sets: assert property (p_cond2_sets) else $error("flag2 or irq2 missing");

    property p_cond2_clear;
        @(posedge clk_i) disable iff (rst_i)
        (wr_en && apb_i.paddr == `SSA_OFF_COND2 && !cond2_hit) |=> !second_condition_flag_r;
    endproperty
    a_cond2_clear: assert property (p_cond2_clear) else $error("flag2 not cleared");

    property p_stretch_hold;
        @(posedge clk_i) disable iff (rst_i)
        (ce_i && block_enable_r && stretch_enable_r && clk_fall && !stretch_active_flag)
        |=> stretch_active_flag && port_b_line_oe_o[`SSA_PB_CLOCK_BIT];
    endproperty
    a_stretch_hold: assert property (p_stretch_hold) else $error("no stretch");

    property p_release;
        @(posedge clk_i) disable iff (rst_i)
        (ce_i && stretch_active_flag && wr_en && apb_i.paddr == `SSA_OFF_SAMPLED)
        |=> !stretch_active_flag;
    endproperty
    a_release: assert property (p_release) else $error("stretch not released");

    property p_sample;
        @(posedge clk_i) disable iff (rst_i)
        (ce_i && clk_rise) |=> sampled_data_bit_r == $past(sync_r.data_line) && new_sample_flag_r;
    endproperty
    a_sample: assert property (p_sample) else $error("sample wrong");

    property p_new_clear;
        @(posedge clk_i) disable iff (rst_i)
        (rd_en && apb_i.paddr == `SSA_OFF_SAMPLED && !clk_rise && !rise_at_setup_r)
        |=> !new_sample_flag_r;
    endproperty
    a_new_clear: assert property (p_new_clear) else $error("new flag not cleared");

    property p_idle_pins;
        @(posedge clk_i) disable iff (rst_i)
        !block_enable_r |-> port_b_line_oe_o == port_b_oe_i;
    endproperty
    a_idle_pins: assert property (p_idle_pins) else $error("pins taken while off");

    c_cond1: cover property (@(posedge clk_i) cond1_hit);
    c_cond2: cover property (@(posedge clk_i) cond2_hit);
    c_stretch: cover property (@(posedge clk_i) $rose(stretch_active_flag));
    c_sample: cover property (@(posedge clk_i) ce_i && clk_rise);
endmodule // ssa_sync_serial_assist

// ===== testbench/ssa_peer.sv
`timescale 1ns/1ns
// ==========
// far-side serial peer on two pulled-up open-drain lines
module ssa_peer (
    input wire logic [7:0] drv_i, // pad drive values from the block
    input wire logic [7:0] oe_i, // pad drive enables from the block
    output logic [7:0] pad_o // resolved pad levels
);
    logic clk_low = 1'b0;
    logic dat_low = 1'b0;
    // released lines float up to the pull-up level, any party may pull low
    always_comb
    begin
        for (int i = 0; i < 8; i++)
            pad_o[i] = oe_i[i] ? drv_i[i] : 1'b1;
        pad_o[4] = pad_o[4] & ~clk_low;
        pad_o[5] = pad_o[5] & ~dat_low;
    end
    // one bit: data moves only while clock is low, lo_ns sets the low time
    task automatic send_bit(input logic d, input int lo_ns);
        #5 clk_low = 1'b1;
        #20 dat_low = ~d;
        #(lo_ns - 20) clk_low = 1'b0;
        #75;
    endtask
    // data change with clock left high, used for framing conditions
    task automatic set_data(input logic d);
        #5 dat_low = ~d;
        #75;
    endtask
endmodule // ssa_peer

// ===== testbench/tb.sv
`timescale 1ns/1ns
// ==========
// self-checking bench for the serial line assist
module tb;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic ce = 1'b1;
    logic exp_q[$];
    ssa_pkg::ssa_apb_req_s apb_i = '0;
    logic [31:0] prdata_o;
    logic pready_o;
    logic pslverr_o;
    logic [7:0] port_b_out_i = 8'h00;
    logic [7:0] port_b_oe_i = 8'h00;
    logic [7:0] pad;
    logic [7:0] drv;
    logic [7:0] oe;
    logic irq1;
    logic irq2;
    logic err;
    logic b;
    logic [31:0] rd;
    int fails = 0;
    int compares = 0;
    int cycles = 0;
    int seed = 57;
    int n1 = 0;
    int n2 = 0;
    int e1 = 0;
    int e2 = 0;
    always #10 clk_i = ~clk_i;
    ssa_sync_serial_assist u_dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .apb_i(apb_i),
        .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
        .port_b_out_i(port_b_out_i), .port_b_oe_i(port_b_oe_i), .port_b_line_i(pad),
        .port_b_line_o(drv), .port_b_line_oe_o(oe), .first_condition_irq_o(irq1),
        .second_condition_irq_o(irq2));
    ssa_peer u_peer (.drv_i(drv), .oe_i(oe), .pad_o(pad));
    // ==========
    // shared tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            fails++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // apb master: hold request until pready sampled high
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_i);
        apb_i <= '{1'b1, 1'b0, wr, a, d};
        @(posedge clk_i);
        apb_i.penable <= 1'b1;
        @(posedge clk_i);
        while (pready_o !== 1'b1)
        begin
            @(posedge clk_i);
        end
        rd = prdata_o;
        err = pslverr_o;
        apb_i <= '0;
    endtask
    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check(rd, exp);
    endtask
    // pin levels cross two sync flops, give them time to land
    task automatic idle;
        repeat (6) @(posedge clk_i);
    endtask
    task automatic tally_and_finish;
        $display("compares=%0d fails=%0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // irq pulse counters and hang guard
    always @(posedge clk_i)
    begin
        cycles++;
        if (irq1 === 1'b1)
            n1++;
        if (irq2 === 1'b1)
            n2++;
        if (cycles == 20000)
        begin
            fails++;
            tally_and_finish;
        end
    end
    // ==========
    // main sequence
    initial
    begin
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        rd_chk(12'h000, 32'h1);
        rd_chk(12'h004, 32'h1);
        rd_chk(12'h008, 32'h0);
        rd_chk(12'h00C, 32'h0);
        rd_chk(12'h010, 32'h0);
        rd_chk(12'h014, 32'h0);
        rd_chk(12'h018, 32'h0);
        check(32'(err), 32'h0);
        rd_chk(12'h01C, 32'h0);
        check(32'(err), 32'h1);
        // disabled: port values pass straight through
        repeat (4)
        begin
            @(posedge clk_i);
            port_b_out_i <= 8'($random(seed));
            port_b_oe_i <= 8'($random(seed)) & 8'hCF;
            @(posedge clk_i);
            #1 check(32'(drv), 32'(port_b_out_i));
            check(32'(oe), 32'(port_b_oe_i));
        end
        apb(1'b1, 12'h008, 32'h1);
        #1 check(32'(oe & 8'h30), 32'h0);
        check(32'(oe & 8'hCF), 32'(port_b_oe_i));
        // clock pad as transmitter; each rise samples the high data line
        apb(1'b1, 12'h004, 32'h0);
        #1 check(32'({oe[4], drv[4]}), 32'h2);
        idle;
        rd_chk(12'h004, 32'h0);
        apb(1'b1, 12'h004, 32'h1);
        u_peer.clk_low <= 1'b1;
        idle;
        rd_chk(12'h004, 32'h0);
        u_peer.clk_low <= 1'b0;
        idle;
        rd_chk(12'h018, 32'h1);
        rd_chk(12'h014, 32'h1);
        rd_chk(12'h018, 32'h0);
        // data pad as transmitter makes both conditions
        apb(1'b1, 12'h000, 32'h0);
        e1++;
        idle;
        rd_chk(12'h000, 32'h0);
        apb(1'b1, 12'h000, 32'h1);
        e2++;
        idle;
        rd_chk(12'h00C, 32'h1);
        rd_chk(12'h010, 32'h1);
        apb(1'b1, 12'h00C, 32'($random(seed)));
        apb(1'b1, 12'h010, 32'h0);
        rd_chk(12'h00C, 32'h0);
        rd_chk(12'h010, 32'h0);
        // receiver: start, random bits, stop from the peer
        u_peer.set_data(1'b0);
        e1++;
        repeat (4)
        begin
            b = 1'($random(seed));
            exp_q.push_back(b);
            u_peer.send_bit(b, 80);
            rd_chk(12'h018, 32'h1);
            rd_chk(12'h014, 32'(exp_q.pop_front()));
            rd_chk(12'h018, 32'h0);
        end
        u_peer.send_bit(1'b0, 80);
        u_peer.set_data(1'b1);
        e2++;
        idle;
        rd_chk(12'h00C, 32'h1);
        rd_chk(12'h010, 32'h1);
        check(32'(n1), 32'(e1));
        check(32'(n2), 32'(e2));
        apb(1'b1, 12'h00C, 32'h0);
        // unconditional stretch, slow peer so the hold is visible
        // clock enable low: a control write must be ignored
        ce <= 1'b0;
        apb(1'b1, 12'h008, 32'h0);
        ce <= 1'b1;
        rd_chk(12'h008, 32'h1);
        apb(1'b1, 12'h008, 32'h3);
        u_peer.send_bit(1'b1, 200);
        rd_chk(12'h008, 32'hB);
        rd_chk(12'h004, 32'h0);
        apb(1'b1, 12'h014, 32'h0);
        idle;
        rd_chk(12'h008, 32'h3);
        rd_chk(12'h014, 32'h1);
        // conditional stretch: only once the first flag is up
        apb(1'b1, 12'h008, 32'h5);
        u_peer.send_bit(1'b1, 200);
        rd_chk(12'h008, 32'h5);
        u_peer.set_data(1'b0);
        e1++;
        u_peer.send_bit(1'b0, 200);
        rd_chk(12'h008, 32'hD);
        apb(1'b1, 12'h014, 32'h0);
        idle;
        rd_chk(12'h008, 32'h5);
        check(32'(n1), 32'(e1));
        tally_and_finish;
    end
endmodule // tb
